//--- spacing_map.svh
/*
 * Offsets, write masks, field ranges and geometry of the channel 0
 * command-spacing tracker.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef SPACING_MAP_SVH
`define SPACING_MAP_SVH

// ==========================================================
// geometry and counter width
`define NUM_RANKS         4
`define NUM_BANKS         8
`define RANK_W            2
`define BANK_W            3
`define GAP_W             9
`define ADDR_W            12
`define GAP_ZERO          9'h000
`define GAP_ONE           9'h001

// ==========================================================
// register offsets in the controller window
`define OFS_RANK_BOUND_1  12'hA02
`define OFS_RANK_BOUND_2  12'hA04
`define OFS_RANK_BOUND_3  12'hA06
`define OFS_RANK01_ATTR   12'hA08
`define OFS_RANK23_ATTR   12'hA0A
`define OFS_SP_PRE        12'hA19
`define OFS_SP_ACT        12'hA1C
`define OFS_SP_WR         12'hA20

// ==========================================================
// writable bits; reserved bits stay zero
`define MASK_RANK_BOUND   16'h03FF
`define MASK_RANK_ATTR    16'hFFFF
`define MASK_SP_PRE       16'hFFFC
`define MASK_SP_ACT       32'h001F_FFFF
`define MASK_SP_WR        16'hFF0F
`define READ_NONE         32'h0000_0000
`define REGS_RESET        '0

// ==========================================================
// field ranges
`define F_LO16            15:0
`define F_BOUND           9:0
`define F_RANK1_ATTR      15:8
`define F_RANK0_ATTR      7:0
`define F_ACT_PRE         15:11
`define F_WR_PRE          10:6
`define F_RD_PRE          5:2
`define F_ACT_ACT         20:17
`define F_PRE_ACT         16:13
`define F_PREALL_ACT      12:9
`define F_REF_ACT         8:0
`define F_ACT_WR          15:12
`define F_WR_WR           11:8
`define F_WR_RD           3:0

`endif

//--- spacing_pkg.sv
/*
 * Types shared by the command-spacing tracker modules.
 * Assumes spacing_map.svh is on the include path.
 */
`include "spacing_map.svh"

package spacing_pkg;

    // ==========================================================
    // scheduler command kinds
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_ACT,
        CMD_PRE,
        CMD_PREALL,
        CMD_REF,
        CMD_READ,
        CMD_WRITE
    } cmd_type;

    // ==========================================================
    // register images plus read data
    typedef struct packed {
        logic [15:0] rb1;
        logic [15:0] rb2;
        logic [15:0] rb3;
        logic [15:0] attr01;
        logic [15:0] attr23;
        logic [15:0] sp_pre;
        logic [31:0] sp_act;
        logic [15:0] sp_wr;
        logic [31:0] rdata;
    } regs_type;

    // one spacing down-counter
    typedef struct packed {
        logic [`GAP_W-1:0] cnt;
    } gap_state_type;

endpackage

//--- cmd_if.sv
/*
 * Decoded scheduler request, one level per command kind.
 * Assumes a single driver (the classifier) and one reader.
 */
`timescale 1ns/1ps
`include "spacing_map.svh"

interface cmd_if;
    logic               req_act;
    logic               req_pre;
    logic               req_preall;
    logic               req_ref;
    logic               req_read;
    logic               req_write;
    logic [`RANK_W-1:0] rank;
    logic [`BANK_W-1:0] bank;

    modport drv (output req_act, req_pre, req_preall, req_ref,
                        req_read, req_write, rank, bank);
    modport sink (input req_act, req_pre, req_preall, req_ref,
                        req_read, req_write, rank, bank);
endinterface

//--- gap_counter.sv
/*
 * One spacing down-counter: loads the programmed gap on the earlier
 * command, blocks the later one until it has run down.
 * Assumes clock, reset and clock enable of the tracker.
 */
`timescale 1ns/1ps
`include "spacing_map.svh"

module gap_counter (
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic              load_i,
    input  wire logic [`GAP_W-1:0] gap_i,
    output logic                   busy_o
);
    spacing_pkg::gap_state_type st_r;
    spacing_pkg::gap_state_type st_nxt;

    // count down, reload keeping the later deadline
    always_comb
    begin
        logic [`GAP_W-1:0] dec;
        logic [`GAP_W-1:0] ld;
        dec = `GAP_ZERO;
        ld = `GAP_ZERO;
        st_nxt = st_r;
        if (st_r.cnt != `GAP_ZERO)
            dec = st_r.cnt - `GAP_ONE;
        if (gap_i != `GAP_ZERO)
            ld = gap_i - `GAP_ONE;   // gap n frees the n-th edge
        if (load_i && (ld > dec))
            st_nxt.cnt = ld;
        else
            st_nxt.cnt = dec;
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            st_r <= `REGS_RESET;
        else if (ce_i)
            st_r <= st_nxt;
    end

    assign busy_o = (st_r.cnt != `GAP_ZERO);
endmodule

//--- command_classify.sv
/*
 * Turns the scheduler's command code into one request level per kind.
 * Assumes inputs from logic on the same clock; purely combinational.
 */
`timescale 1ns/1ps
`include "spacing_map.svh"

module command_classify (
    input  wire logic               cmd_valid_i,
    input  wire spacing_pkg::cmd_type cmd_i,
    input  wire logic [`RANK_W-1:0] rank_i,
    input  wire logic [`BANK_W-1:0] bank_i,
    cmd_if.drv                      req
);
    // one-hot request from the command code
    always_comb
    begin
        req.req_act = 1'b0;
        req.req_pre = 1'b0;
        req.req_preall = 1'b0;
        req.req_ref = 1'b0;
        req.req_read = 1'b0;
        req.req_write = 1'b0;
        if (cmd_valid_i)
        begin
            unique case (cmd_i)
                spacing_pkg::CMD_ACT:    req.req_act = 1'b1;
                spacing_pkg::CMD_PRE:    req.req_pre = 1'b1;
                spacing_pkg::CMD_PREALL: req.req_preall = 1'b1;
                spacing_pkg::CMD_REF:    req.req_ref = 1'b1;
                spacing_pkg::CMD_READ:   req.req_read = 1'b1;
                spacing_pkg::CMD_WRITE:  req.req_write = 1'b1;
                default:                 req.req_act = 1'b0;
            endcase
        end
    end

    assign req.rank = rank_i;
    assign req.bank = bank_i;
endmodule

//--- dram_command_spacing_tracker.sv
/*
 * Channel 0 command-spacing tracker with rank geometry registers.
 * Holds the spacing, boundary and attribute registers, gates the
 * scheduler's next command per rank or rank-bank, and starts the
 * matching spacing counters when a command issues.
 * Assumes the scheduler and register master run on mclk_i, present
 * at most one command per cycle and issue only when cmd_ready_o.
 */
`timescale 1ns/1ps
`include "spacing_map.svh"

module dram_command_spacing_tracker (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic [`ADDR_W-1:0]   reg_addr_i,
    input  wire logic [31:0]          reg_wdata_i,
    output logic      [31:0]          reg_rdata_o,
    input  wire logic                 cmd_valid_i,
    input  wire spacing_pkg::cmd_type cmd_i,
    input  wire logic [`RANK_W-1:0]   cmd_rank_i,
    input  wire logic [`BANK_W-1:0]   cmd_bank_i,
    output logic                      cmd_ready_o,
    output logic      [9:0]           rank_bound_addr_1_o,
    output logic      [9:0]           rank_bound_addr_2_o,
    output logic      [9:0]           rank_bound_addr_3_o,
    output logic      [7:0]           rank0_attr_o,
    output logic      [7:0]           rank1_attr_o,
    output logic      [15:0]          rank23_attr_o
);
    // ==========================================================
    // state and decoded request
    spacing_pkg::regs_type st_r;
    spacing_pkg::regs_type st_nxt;
    logic [31:0]           read_image;

    cmd_if req ();

    // per rank-bank counters still running
    logic [`NUM_RANKS-1:0][`NUM_BANKS-1:0] act_pre_busy;
    logic [`NUM_RANKS-1:0][`NUM_BANKS-1:0] wr_pre_busy;
    logic [`NUM_RANKS-1:0][`NUM_BANKS-1:0] rd_pre_busy;
    logic [`NUM_RANKS-1:0][`NUM_BANKS-1:0] pre_act_busy;
    logic [`NUM_RANKS-1:0][`NUM_BANKS-1:0] act_wr_busy;
    // per rank counters still running
    logic [`NUM_RANKS-1:0]                 act_act_busy;
    logic [`NUM_RANKS-1:0]                 preall_act_busy;
    logic [`NUM_RANKS-1:0]                 ref_act_busy;
    logic [`NUM_RANKS-1:0]                 wr_wr_busy;
    logic [`NUM_RANKS-1:0]                 wr_rd_busy;

    // permits for the current request
    logic                                  ok_act;
    logic                                  ok_pre;
    logic                                  ok_preall;
    logic                                  ok_read;
    logic                                  ok_write;
    // commands that issue this cycle
    logic                                  iss_act;
    logic                                  iss_pre;
    logic                                  iss_preall;
    logic                                  iss_ref;
    logic                                  iss_read;
    logic                                  iss_write;

    // ==========================================================
    // decode helpers
    function automatic logic rank_hit(input logic [`RANK_W-1:0] rk,
                                      input int r);
        return rk == `RANK_W'(r);
    endfunction

    function automatic logic bank_hit(input logic [`BANK_W-1:0] bk,
                                      input int b);
        return bk == `BANK_W'(b);
    endfunction

    function automatic logic addr_hit(input logic [`ADDR_W-1:0] a,
                                      input logic [`ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    // ==========================================================
    // command classification
    command_classify u_classify (
        .cmd_valid_i (cmd_valid_i),
        .cmd_i       (cmd_i),
        .rank_i      (cmd_rank_i),
        .bank_i      (cmd_bank_i),
        .req         (req)
    );

    // ==========================================================
    // permits from the running counters
    always_comb
    begin
        // act held by earlier act, precharge-all or refresh to rank
        // and by earlier pre to rank-bank
        ok_act = !act_act_busy[req.rank]
               && !preall_act_busy[req.rank]
               && !ref_act_busy[req.rank]
               && !pre_act_busy[req.rank][req.bank];
        ok_pre = !act_pre_busy[req.rank][req.bank]
               && !wr_pre_busy[req.rank][req.bank]
               && !rd_pre_busy[req.rank][req.bank];
        // precharge-all waits for every bank of the rank
        ok_preall = !(|(act_pre_busy[req.rank]
                     | wr_pre_busy[req.rank]
                     | rd_pre_busy[req.rank]));
        // read held after write to rank
        ok_read = !wr_rd_busy[req.rank];
        // write held after act to rank-bank
        // write held after write to rank
        ok_write = !act_wr_busy[req.rank][req.bank]
                 && !wr_wr_busy[req.rank];
    end

    // ready for the kind requested; refresh is held only while ce_i is low
    assign cmd_ready_o = ce_i
                       && ((req.req_act && ok_act)
                        || (req.req_pre && ok_pre)
                        || (req.req_preall && ok_preall)
                        || req.req_ref
                        || (req.req_read && ok_read)
                        || (req.req_write && ok_write));

    // issue strobes start the counters
    assign iss_act = ce_i && req.req_act && ok_act;
    assign iss_pre = ce_i && req.req_pre && ok_pre;
    assign iss_preall = ce_i && req.req_preall && ok_preall;
    assign iss_ref = ce_i && req.req_ref;
    assign iss_read = ce_i && req.req_read && ok_read;
    assign iss_write = ce_i && req.req_write && ok_write;

    // ==========================================================
    // spacing counters
    for (genvar r = 0; r < `NUM_RANKS; r++)
    begin : g_rank
        gap_counter u_act_act (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .ce_i   (ce_i),
            .load_i (iss_act && rank_hit(req.rank, r)),
            .gap_i  (`GAP_W'(st_r.sp_act[`F_ACT_ACT])),
            .busy_o (act_act_busy[r])
        );
        gap_counter u_preall_act (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .ce_i   (ce_i),
            .load_i (iss_preall && rank_hit(req.rank, r)),
            .gap_i  (`GAP_W'(st_r.sp_act[`F_PREALL_ACT])),
            .busy_o (preall_act_busy[r])
        );
        gap_counter u_ref_act (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .ce_i   (ce_i),
            .load_i (iss_ref && rank_hit(req.rank, r)),
            .gap_i  (`GAP_W'(st_r.sp_act[`F_REF_ACT])),
            .busy_o (ref_act_busy[r])
        );
        gap_counter u_wr_wr (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .ce_i   (ce_i),
            .load_i (iss_write && rank_hit(req.rank, r)),
            .gap_i  (`GAP_W'(st_r.sp_wr[`F_WR_WR])),
            .busy_o (wr_wr_busy[r])
        );
        gap_counter u_wr_rd (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .ce_i   (ce_i),
            .load_i (iss_write && rank_hit(req.rank, r)),
            .gap_i  (`GAP_W'(st_r.sp_wr[`F_WR_RD])),
            .busy_o (wr_rd_busy[r])
        );

        for (genvar b = 0; b < `NUM_BANKS; b++)
        begin : g_bank
            logic hit;
            assign hit = rank_hit(req.rank, r) && bank_hit(req.bank, b);

            gap_counter u_act_pre (
                .mclk_i (mclk_i),
                .rst_i  (rst_i),
                .ce_i   (ce_i),
                .load_i (iss_act && hit),
                .gap_i  (`GAP_W'(st_r.sp_pre[`F_ACT_PRE])),
                .busy_o (act_pre_busy[r][b])
            );
            gap_counter u_wr_pre (
                .mclk_i (mclk_i),
                .rst_i  (rst_i),
                .ce_i   (ce_i),
                .load_i (iss_write && hit),
                .gap_i  (`GAP_W'(st_r.sp_pre[`F_WR_PRE])),
                .busy_o (wr_pre_busy[r][b])
            );
            gap_counter u_rd_pre (
                .mclk_i (mclk_i),
                .rst_i  (rst_i),
                .ce_i   (ce_i),
                .load_i (iss_read && hit),
                .gap_i  (`GAP_W'(st_r.sp_pre[`F_RD_PRE])),
                .busy_o (rd_pre_busy[r][b])
            );
            gap_counter u_pre_act (
                .mclk_i (mclk_i),
                .rst_i  (rst_i),
                .ce_i   (ce_i),
                .load_i (iss_pre && hit),
                .gap_i  (`GAP_W'(st_r.sp_act[`F_PRE_ACT])),
                .busy_o (pre_act_busy[r][b])
            );
            gap_counter u_act_wr (
                .mclk_i (mclk_i),
                .rst_i  (rst_i),
                .ce_i   (ce_i),
                .load_i (iss_act && hit),
                .gap_i  (`GAP_W'(st_r.sp_act[`F_ACT_WR] & '0)
                         | `GAP_W'(st_r.sp_wr[`F_ACT_WR])),
                .busy_o (act_wr_busy[r][b])
            );
        end
    end

    // ==========================================================
    // register read image; unmapped offsets read zero
    always_comb
    begin
        case (reg_addr_i)
            `OFS_RANK_BOUND_1: read_image = 32'(st_r.rb1);
            `OFS_RANK_BOUND_2: read_image = 32'(st_r.rb2);
            `OFS_RANK_BOUND_3: read_image = 32'(st_r.rb3);
            `OFS_RANK01_ATTR:  read_image = 32'(st_r.attr01);
            `OFS_RANK23_ATTR:  read_image = 32'(st_r.attr23);
            `OFS_SP_PRE:       read_image = 32'(st_r.sp_pre);
            `OFS_SP_ACT:       read_image = st_r.sp_act;
            `OFS_SP_WR:        read_image = 32'(st_r.sp_wr);
            default:           read_image = `READ_NONE;
        endcase
    end

    // ==========================================================
    // register writes and read capture
    always_comb
    begin
        st_nxt = st_r;
        if (reg_wr_i)
        begin
            // boundary and attribute fields, reserved bits kept zero
            if (addr_hit(reg_addr_i, `OFS_RANK_BOUND_1))
                st_nxt.rb1 = reg_wdata_i[`F_LO16] & `MASK_RANK_BOUND;
            if (addr_hit(reg_addr_i, `OFS_RANK_BOUND_2))
                st_nxt.rb2 = reg_wdata_i[`F_LO16] & `MASK_RANK_BOUND;
            if (addr_hit(reg_addr_i, `OFS_RANK_BOUND_3))
                st_nxt.rb3 = reg_wdata_i[`F_LO16] & `MASK_RANK_BOUND;
            if (addr_hit(reg_addr_i, `OFS_RANK01_ATTR))
                st_nxt.attr01 = reg_wdata_i[`F_LO16] & `MASK_RANK_ATTR;
            if (addr_hit(reg_addr_i, `OFS_RANK23_ATTR))
                st_nxt.attr23 = reg_wdata_i[`F_LO16] & `MASK_RANK_ATTR;
            // spacing registers, reserved bits kept zero
            if (addr_hit(reg_addr_i, `OFS_SP_PRE))
                st_nxt.sp_pre = reg_wdata_i[`F_LO16] & `MASK_SP_PRE;
            if (addr_hit(reg_addr_i, `OFS_SP_ACT))
                st_nxt.sp_act = reg_wdata_i & `MASK_SP_ACT;
            if (addr_hit(reg_addr_i, `OFS_SP_WR))
                st_nxt.sp_wr = reg_wdata_i[`F_LO16] & `MASK_SP_WR;
        end
        // read returns the value before a same-cycle write
        if (reg_rd_i)
            st_nxt.rdata = read_image;
    end

    // all registers clear to zero on reset
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            st_r <= `REGS_RESET;
        else if (ce_i)
            st_r <= st_nxt;
    end

    // ==========================================================
    // outputs straight from the register images
    assign reg_rdata_o = st_r.rdata;
    assign rank_bound_addr_1_o = st_r.rb1[`F_BOUND];
    assign rank_bound_addr_2_o = st_r.rb2[`F_BOUND];
    assign rank_bound_addr_3_o = st_r.rb3[`F_BOUND];
    assign rank1_attr_o = st_r.attr01[`F_RANK1_ATTR];
    assign rank0_attr_o = st_r.attr01[`F_RANK0_ATTR];
    assign rank23_attr_o = st_r.attr23;
endmodule

//--- spacing_tracker_properties.sv
/* checker: spacing holds and register behaviour at the tracker ports.
   assumes spacing_pkg and spacing_map.svh are compiled first. */
`timescale 1ns/1ps
`include "spacing_map.svh"
module spacing_tracker_properties (
    input wire logic                 mclk_i,
    input wire logic                 rst_i,
    input wire logic                 ce_i,
    input wire logic                 reg_wr_i,
    input wire logic                 reg_rd_i,
    input wire logic [11:0]          reg_addr_i,
    input wire logic [31:0]          reg_wdata_i,
    input wire logic [31:0]          reg_rdata_o,
    input wire logic                 cmd_valid_i,
    input wire spacing_pkg::cmd_type cmd_i,
    input wire logic [1:0]           cmd_rank_i,
    input wire logic [2:0]           cmd_bank_i,
    input wire logic                 cmd_ready_o,
    input wire logic [9:0]           rank_bound_addr_1_o,
    input wire logic [9:0]           rank_bound_addr_2_o,
    input wire logic [9:0]           rank_bound_addr_3_o,
    input wire logic [7:0]           rank0_attr_o,
    input wire logic [7:0]           rank1_attr_o,
    input wire logic [15:0]          rank23_attr_o
);
    logic [31:0] act_sp_r;
    logic [15:0] wr_sp_r;
    logic [31:0] wd_r;
    logic [1:0]  rank_r;
    wire logic iss  = ce_i && cmd_valid_i && cmd_ready_o;
    wire logic wacc = ce_i && reg_wr_i;
    wire logic rdy  = cmd_ready_o && cmd_valid_i && cmd_rank_i == rank_r;
    wire logic iss_wr = iss && cmd_i == spacing_pkg::CMD_WRITE;
    // ==========================================================
    // shadows of the spacing registers and last request
    always_ff @(posedge mclk_i)
    begin
        wd_r   <= reg_wdata_i;
        rank_r <= cmd_rank_i;
        act_sp_r <= rst_i ? 32'h0000_0000 :
            (wacc && reg_addr_i == `OFS_SP_ACT) ? reg_wdata_i : act_sp_r;
        wr_sp_r <= rst_i ? 16'h0000 :
            (wacc && reg_addr_i == `OFS_SP_WR) ? reg_wdata_i[15:0] : wr_sp_r;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // assertions
    reset_clear_a: assert property (
        $fell(rst_i) |-> reg_rdata_o == 32'h0000_0000 && rank0_attr_o == 8'h00
        && rank_bound_addr_1_o == 10'h000 && rank23_attr_o == 16'h0000)
        else $error("outputs not clear after reset");
    bound_write_a: assert property (
        wacc && reg_addr_i == `OFS_RANK_BOUND_1
        |=> rank_bound_addr_1_o == wd_r[9:0])
        else $error("boundary output not updated");
    bound_rsvd_a: assert property (
        ce_i && reg_rd_i && reg_addr_i == `OFS_RANK_BOUND_2
        |=> reg_rdata_o[31:10] == 22'h000000)
        else $error("boundary reserved bits not zero");
    attr_write_a: assert property (
        wacc && reg_addr_i == `OFS_RANK01_ATTR
        |=> {rank1_attr_o, rank0_attr_o} == wd_r[15:0])
        else $error("attribute bytes wrong");
    act_act_hold_a: assert property (
        iss && cmd_i == spacing_pkg::CMD_ACT && act_sp_r[20:17] > 4'h1
        |=> !(rdy && cmd_i == spacing_pkg::CMD_ACT))
        else $error("activate let through too early");
    ref_act_hold_a: assert property (
        iss && cmd_i == spacing_pkg::CMD_REF && act_sp_r[8:0] > 9'h001
        |=> !(rdy && cmd_i == spacing_pkg::CMD_ACT))
        else $error("activate after refresh too early");
    wr_wr_hold_a: assert property (
        iss_wr && wr_sp_r[11:8] > 4'h1
        |=> !(rdy && cmd_i == spacing_pkg::CMD_WRITE))
        else $error("write after write too early");
    wr_rd_hold_a: assert property (
        iss_wr && wr_sp_r[3:0] > 4'h1
        |=> !(rdy && cmd_i == spacing_pkg::CMD_READ))
        else $error("read after write too early");
endmodule
bind dram_command_spacing_tracker spacing_tracker_properties
    spacing_tracker_properties_i (.mclk_i, .rst_i, .ce_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .cmd_valid_i,
    .cmd_i, .cmd_rank_i, .cmd_bank_i, .cmd_ready_o, .rank_bound_addr_1_o,
    .rank_bound_addr_2_o, .rank_bound_addr_3_o, .rank0_attr_o,
    .rank1_attr_o, .rank23_attr_o);

//--- dram_device_model.sv
/* device side model: reports each command let through, with the
   clocks since the one before. assumes issue is sampled on mclk_i. */
`timescale 1ns/1ps
module dram_device_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       iss_i,
    output logic            seen_o,
    output logic      [5:0] gap_o
);
    logic [5:0] since_r;
    // ==========================================================
    // saturating count of clocks since the last command
    always_ff @(posedge mclk_i)
    begin
        seen_o  <= iss_i && !rst_i;
        gap_o   <= since_r;
        since_r <= (rst_i || iss_i) ? 6'h01
                 : since_r + {5'h00, since_r != 6'h3F};
    end
endmodule

//--- dram_command_spacing_tracker_bench.sv
/* bench: register checks and command spacing pairs.
   assumes the design files are compiled first. */
`timescale 1ns/1ps
module dram_command_spacing_tracker_bench;
    logic        mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, cmd_valid_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
    logic [1:0]  cmd_rank_i = 2'h0;
    logic [2:0]  cmd_bank_i = 3'h0;
    logic        cmd_ready_o, seen;
    logic [5:0]  gap;
    logic [31:0] exp_q[$];
    int          err_total = 0, n_tests = 0, cyc = 0, seed = 32'h243cb2fa;
    spacing_pkg::cmd_type cmd_i = spacing_pkg::CMD_NONE;
    int ofs[9] = '{12'hA02, 12'hA04, 12'hA06, 12'hA08, 12'hA0A, 12'hA19,
                   12'hA1C, 12'hA20, 12'hA00};
    logic [31:0] msk[9] = '{32'h3FF, 32'h3FF, 32'h3FF, 32'hFFFF, 32'hFFFF,
                            32'hFFFC, 32'h1FFFFF, 32'hFF0F, 32'h0};
    // first, second, register, low bit, bank step, rank step, free
    int tab[12][7] = '{'{1,2,12'hA19,11,0,0,0}, '{6,2,12'hA19,6,0,0,0},
        '{5,2,12'hA19,2,0,0,0}, '{1,1,12'hA1C,17,1,0,0},
        '{2,1,12'hA1C,13,0,0,0}, '{3,1,12'hA1C,9,0,0,0},
        '{4,1,12'hA1C,0,0,0,0}, '{1,6,12'hA20,12,0,0,0},
        '{6,6,12'hA20,8,1,0,0}, '{6,5,12'hA20,0,0,0,0},
        '{1,1,12'hA1C,17,0,1,1}, '{1,2,12'hA19,11,1,0,1}};
    dram_command_spacing_tracker dram_command_spacing_tracker_i (.mclk_i,
        .rst_i, .ce_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
        .reg_rdata_o, .cmd_valid_i, .cmd_i, .cmd_rank_i, .cmd_bank_i,
        .cmd_ready_o, .rank_bound_addr_1_o(), .rank_bound_addr_2_o(),
        .rank_bound_addr_3_o(), .rank0_attr_o(), .rank1_attr_o(),
        .rank23_attr_o());
    dram_device_model dram_device_model_i (.mclk_i, .rst_i,
        .iss_i(ce_i && cmd_valid_i && cmd_ready_o), .seen_o(seen),
        .gap_o(gap));
    initial forever #20 mclk_i = ~mclk_i;
    // ==========================================================
    // bus and command drivers; rd and cmd note their expected result, wr notes none
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge mclk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(negedge mclk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge mclk_i);
        reg_rd_i = 1'b0;
    endtask
    task automatic cmd(input int c, input int r, input int b, input int e);
        int k = 0;
        exp_q.push_back(32'(e));
        @(negedge mclk_i);
        cmd_valid_i = 1'b1;
        cmd_i = spacing_pkg::cmd_type'(c);
        cmd_rank_i = 2'(r);
        cmd_bank_i = 3'(b);
        #1;
        while (cmd_ready_o !== 1'b1 && k < 40)
        begin
            @(negedge mclk_i);
            #1;
            k++;
        end
        @(posedge mclk_i);
    endtask
    task automatic check(input string what, input logic [31:0] v);
        logic [31:0] e;
        e = exp_q.size() ? exp_q.pop_front() : 32'hFFFF_FFFF;
        n_tests++;
        if (v !== e)
        begin
            $display("unexpected %s expected %h seen %h", what, e, v);
            err_total++;
        end
    endtask
    task automatic stop_test;
        if (exp_q.size() != 0)
            err_total++;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // watcher: oldest note against each result, plus the time limit
    always @(posedge mclk_i)
    begin
        logic rd_s;
        rd_s = reg_rd_i;
        #1;
        if (rd_s)
            check("read data", reg_rdata_o);
        if (seen === 1'b1)
            check("command gap", {26'h0, gap});
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end
    // ==========================================================
    // main sequence
    initial
    begin
        int n;
        int e;
        logic [31:0] d;
        repeat (3) @(negedge mclk_i);
        rst_i = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            d = $random(seed);
            rd(12'(ofs[i]), 32'h0);
            wr(12'(ofs[i]), d);
            rd(12'(ofs[i]), d & msk[i]);
        end
        // attributes back to zero while ranks count as empty
        wr(12'hA08, 32'h0);
        wr(12'hA0A, 32'h0);
        @(negedge mclk_i);
        rst_i = 1'b1;
        @(negedge mclk_i);
        rst_i = 1'b0;
        rd(12'hA1C, 32'h0);
        $display("test registers done");
        for (int p = 0; p < 24; p++)
        begin
            repeat (64) @(negedge mclk_i);
            n = p > 11 ? 15 : $random(seed) & 15;
            e = (tab[p % 12][6] != 0 || n < 2) ? 1 : n;
            wr(12'(tab[p % 12][2]), 32'(n) << tab[p % 12][3]);
            cmd(tab[p % 12][0], 0, 0, 63);
            cmd(tab[p % 12][1], tab[p % 12][5], tab[p % 12][4], e);
            @(negedge mclk_i);
            cmd_valid_i = 1'b0;
        end
        $display("test spacing done");
        stop_test();
    end
endmodule
